// >>> verilog/rxo_params.svh
// Purpose: constants of the receiver control words and timing
// Assumes: 200 MHz system clock
// Notes: included by the package and by the design modules
`ifndef RXO_PARAMS_SVH
`define RXO_PARAMS_SVH

// command headers (upper byte)
`define RXO_HDR_CLK 8'hC2
`define RXO_HDR_OFS 8'hC6
`define RXO_HDR_FLT 8'hC4

// power-on values of the words
`define RXO_POR_CLK 16'hC213
`define RXO_POR_OFS 16'hC687
`define RXO_POR_FLT 16'hC462

// field positions
`define RXO_CLK_DIV_LSB 5
`define RXO_CLK_LF_BIT 4
`define RXO_OFS_ADD_BIT 0
`define RXO_OFS_OE_BIT 1
`define RXO_OFS_FINE_BIT 2
`define RXO_OFS_STB_BIT 3
`define RXO_OFS_LIM_LSB 4
`define RXO_OFS_MODE_LSB 6

// supply threshold: base and step in millivolts
`define RXO_THR_BASE_MV 12'h7D0
`define RXO_THR_STEP_MV 12'h064

// timing
`define RXO_CLK_MHZ 200
`define RXO_MEAS_NS 10000
`define RXO_MEAS_CYC ((`RXO_MEAS_NS * `RXO_CLK_MHZ) / 1000)
`define RXO_FINE_MUL 4
`define RXO_LF_KHZ 32
`define RXO_LF_HALF_CYC ((`RXO_CLK_MHZ * 1000) / (2 * `RXO_LF_KHZ))

// offset register width
`define RXO_OFS_W 8

// digital filter integrator and hysteresis levels
`define RXO_FLT_HI 4'hC
`define RXO_FLT_LO 4'h3

`endif

// >>> verilog/rxo_pkg.sv
// Purpose: types of the receiver control block
// Assumes: rxo_params.svh holds the numbers
// Notes: command words travel as packed structs
`include "rxo_params.svh"

package rxo_pkg;

    typedef struct packed {
        logic [7:0] hdr;
        logic [2:0] clk_out_div_sel;
        logic lf_clk_en;
        logic [3:0] supply_thresh_code;
    } rxo_clk_cmd_t;

    typedef struct packed {
        logic [7:0] hdr;
        logic [1:0] auto_mode_sel;
        logic [1:0] offset_range_limit;
        logic offset_strobe;
        logic fine_measure_en;
        logic out_reg_en;
        logic synth_add_en;
    } rxo_ofs_cmd_t;

    typedef struct packed {
        logic [7:0] hdr;
        logic recovery_auto_lock;
        logic recovery_fast_sel;
        logic auto_sleep_dis;
        logic filter_type_sel;
        logic [3:0] unused;
    } rxo_flt_cmd_t;

    typedef enum logic [1:0] {
        RXO_MODE_MANUAL = 2'b00,
        RXO_MODE_ONCE = 2'b01,
        RXO_MODE_DROP = 2'b10,
        RXO_MODE_KEEP = 2'b11
    } rxo_mode_t;

endpackage : rxo_pkg

// >>> verilog/rxo_clk_out.sv
// Purpose: divided clock output and low frequency sleep clock
// Assumes: 200 MHz system clock
// Notes: output stops low when neither clock applies
`timescale 1ns/10ps
`default_nettype none
`include "rxo_params.svh"

module rxo_clk_out (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0] div_sel_in,
    input wire logic lf_en_in,
    input wire logic xtal_on_in,
    input wire logic sleep_in,
    input wire logic disable_in,
    output logic clk_out
);
    logic [11:0] cnt_r;
    logic [11:0] half_nxt;
    logic run_fast;
    logic run_slow;

    // half periods in system cycles for 1 .. 10 MHz
    always_comb
    begin
        case (div_sel_in)
            3'h0: half_nxt = 12'h064;
            3'h1: half_nxt = 12'h050;
            3'h2: half_nxt = 12'h03C;
            3'h3: half_nxt = 12'h032;
            3'h4: half_nxt = 12'h028;
            3'h5: half_nxt = 12'h01E;
            3'h6: half_nxt = 12'h014;
            default: half_nxt = 12'h00A;
        endcase
        if (sleep_in)
            half_nxt = 12'((`RXO_LF_HALF_CYC));
    end

    assign run_fast = xtal_on_in & ~sleep_in & ~disable_in;
    assign run_slow = sleep_in & lf_en_in;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            cnt_r <= 12'h000;
            clk_out <= 1'b0;
        end
        else if (!(run_fast | run_slow))
        begin
            cnt_r <= 12'h000;
            clk_out <= 1'b0;
        end
        else if (cnt_r >= half_nxt - 12'h001)
        begin
            cnt_r <= 12'h000;
            clk_out <= ~clk_out;
        end
        else
            cnt_r <= cnt_r + 12'h001;
    end
endmodule : rxo_clk_out

`default_nettype wire

// >>> verilog/rxo_ctrl_top.sv
// Purpose: clock output, supply threshold, offset correction and data filter words
// Assumes: serial control pins sampled synchronous to CLK_SYS_IN
// Notes: words apply when the select line rises after exactly 16 bits
`timescale 1ns/10ps
`default_nettype none
`include "rxo_params.svh"

module rxo_ctrl_top #(
    parameter int OW = `RXO_OFS_W,
    parameter int MEAS_CYC = `RXO_MEAS_CYC
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    // serial control interface
    input wire logic SCK_IN,
    input wire logic SDI_IN,
    input wire logic SEL_B_IN,
    output logic SDO_OUT,
    // receiver state
    input wire logic XTAL_ON_IN,
    input wire logic SLEEP_IN,
    input wire logic CLK_OUT_DISABLE_IN,
    input wire logic [1:0] VALID_IND_SRC_SEL_IN,
    input wire logic SIGNAL_LEVEL_FLAG_IN,
    input wire logic DATA_QUALITY_FLAG_IN,
    input wire logic RECOVERY_LOCK_IN,
    input wire logic FIFO_IRQ_IN,
    input wire logic signed [OW-1:0] FREQ_ERR_IN,
    // data path
    input wire logic DEMOD_IN,
    input wire logic ANALOG_FILT_IN,
    input wire logic [6:0] BIT_RATE_DIV_IN,
    // clock and supply outputs
    output logic CLK_OUT_OUT,
    output logic [11:0] SUPPLY_THRESH_MV_OUT,
    // offset correction outputs
    output logic VALID_DATA_IND_OUT,
    output logic signed [OW-1:0] FREQ_OFFSET_OUT,
    output logic signed [OW-1:0] SYNTH_OFFSET_OUT,
    output logic FINE_MEASURE_OUT,
    output logic MEASURE_TOGGLE_OUT,
    // filter and recovery outputs
    output logic RECOVERY_FAST_OUT,
    output logic STANDBY_REQ_OUT,
    output logic FILTER_ANALOG_OUT,
    output logic FILT_DATA_OUT
);
    import rxo_pkg::*;

    localparam int CW = $clog2(MEAS_CYC * `RXO_FINE_MUL + 1);

    rxo_clk_cmd_t clk_cmd_r;
    rxo_ofs_cmd_t ofs_cmd_r;
    rxo_flt_cmd_t flt_cmd_r;
    rxo_mode_t mode;

    logic [15:0] shift_r;
    logic [4:0] bits_r;
    logic sck_prev_r;
    logic sel_b_prev_r;
    logic read_cmd_r;
    logic sck_rise;
    logic word_done;

    logic [CW-1:0] meas_cnt_r;
    logic [CW-1:0] meas_len;
    logic meas_end;
    logic valid_data_ind;
    logic vdi_prev_r;
    logic vdi_whole_r;
    logic signed [OW-1:0] latest_r;
    logic signed [OW-1:0] prev_meas_r;
    logic have_prev_r;
    logic signed [OW-1:0] offset_r;
    logic signed [OW-1:0] clamped;
    logic strobe_prev_r;
    logic once_done_r;
    logic auto_ok;

    logic [6:0] tick_cnt_r;
    logic [3:0] acc_r;
    logic dig_out_r;

    // serial word capture
    assign sck_rise = SCK_IN & ~sck_prev_r;
    assign word_done = ~sel_b_prev_r & SEL_B_IN & (bits_r == 5'h10);

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            sck_prev_r <= 1'b0;
            sel_b_prev_r <= 1'b1;
            shift_r <= 16'h0000;
            bits_r <= 5'h00;
        end
        else
        begin
            sck_prev_r <= SCK_IN;
            sel_b_prev_r <= SEL_B_IN;
            if (SEL_B_IN)
                bits_r <= 5'h00;
            else if (sck_rise)
            begin
                shift_r <= {shift_r[14:0], SDI_IN};
                if (bits_r != 5'h1F)
                    bits_r <= bits_r + 5'h01;
            end
        end
    end

    // status read: a leading zero bit selects the read command
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            read_cmd_r <= 1'b0;
            SDO_OUT <= 1'b0;
        end
        else
        begin
            if (SEL_B_IN)
                read_cmd_r <= 1'b0;
            else if (sck_rise && bits_r == 5'h00)
                read_cmd_r <= ~SDI_IN;
            SDO_OUT <= read_cmd_r & ~SEL_B_IN & MEASURE_TOGGLE_OUT;
        end
    end

    // command word registers
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            clk_cmd_r <= `RXO_POR_CLK;
            ofs_cmd_r <= `RXO_POR_OFS;
            flt_cmd_r <= `RXO_POR_FLT;
        end
        else if (word_done)
        begin
            if (shift_r[15:8] == `RXO_HDR_CLK)
                clk_cmd_r <= shift_r;
            if (shift_r[15:8] == `RXO_HDR_OFS)
                ofs_cmd_r <= shift_r;
            if (shift_r[15:8] == `RXO_HDR_FLT)
                flt_cmd_r <= shift_r;
        end
    end

    // clock output
    rxo_clk_out u_clk_out (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .div_sel_in(clk_cmd_r.clk_out_div_sel),
        .lf_en_in(clk_cmd_r.lf_clk_en),
        .xtal_on_in(XTAL_ON_IN),
        .sleep_in(SLEEP_IN),
        .disable_in(CLK_OUT_DISABLE_IN),
        .clk_out(CLK_OUT_OUT)
    );

    // supply threshold in millivolts
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
            SUPPLY_THRESH_MV_OUT <= `RXO_THR_BASE_MV;
        else
            SUPPLY_THRESH_MV_OUT <= `RXO_THR_BASE_MV
                + 12'(clk_cmd_r.supply_thresh_code * `RXO_THR_STEP_MV);
    end

    // valid-data source
    always_comb
    begin
        case (VALID_IND_SRC_SEL_IN)
            2'h0: valid_data_ind = SIGNAL_LEVEL_FLAG_IN;
            2'h1: valid_data_ind = DATA_QUALITY_FLAG_IN;
            2'h2: valid_data_ind = RECOVERY_LOCK_IN;
            default: valid_data_ind = 1'b1;
        endcase
    end

    // measurement cycle timer
    assign meas_len = ofs_cmd_r.fine_measure_en
        ? CW'(MEAS_CYC * `RXO_FINE_MUL) : CW'(MEAS_CYC);
    assign meas_end = (meas_cnt_r >= meas_len - CW'(1));
    assign mode = rxo_mode_t'(ofs_cmd_r.auto_mode_sel);

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            meas_cnt_r <= '0;
            latest_r <= '0;
            MEASURE_TOGGLE_OUT <= 1'b0;
        end
        else if (meas_end)
        begin
            meas_cnt_r <= '0;
            latest_r <= FREQ_ERR_IN;
            MEASURE_TOGGLE_OUT <= ~MEASURE_TOGGLE_OUT;
        end
        else
            meas_cnt_r <= meas_cnt_r + CW'(1);
    end

    // valid-data held over the whole cycle, and previous result
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            vdi_whole_r <= 1'b1;
            vdi_prev_r <= 1'b0;
            prev_meas_r <= '0;
            have_prev_r <= 1'b0;
        end
        else
        begin
            vdi_prev_r <= valid_data_ind;
            if (meas_end)
            begin
                vdi_whole_r <= 1'b1;
                prev_meas_r <= FREQ_ERR_IN;
                have_prev_r <= vdi_whole_r & valid_data_ind;
            end
            else if (!valid_data_ind)
                vdi_whole_r <= 1'b0;
        end
    end

    assign auto_ok = meas_end & vdi_whole_r & valid_data_ind & have_prev_r
        & (FREQ_ERR_IN == prev_meas_r);

    // range limit
    function automatic logic signed [OW-1:0] lim_fn(
        input logic signed [OW-1:0] v,
        input logic [1:0] code
    );
        logic signed [OW-1:0] m;
        m = (code == 2'h1) ? OW'(4) : (code == 2'h2) ? OW'(2) : OW'(1);
        if (code == 2'h0)
            lim_fn = v;
        else if (v > m)
            lim_fn = m;
        else if (v < -m)
            lim_fn = -m;
        else
            lim_fn = v;
    endfunction : lim_fn

    assign clamped = lim_fn(latest_r, ofs_cmd_r.offset_range_limit);

    // offset output register
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            offset_r <= '0;
            strobe_prev_r <= 1'b0;
            once_done_r <= 1'b0;
        end
        else
        begin
            strobe_prev_r <= ofs_cmd_r.offset_strobe;
            case (mode)
                RXO_MODE_MANUAL:
                    if (ofs_cmd_r.offset_strobe && !strobe_prev_r)
                        offset_r <= clamped;
                RXO_MODE_ONCE:
                    if (auto_ok && !once_done_r)
                    begin
                        offset_r <= lim_fn(FREQ_ERR_IN, ofs_cmd_r.offset_range_limit);
                        once_done_r <= 1'b1;
                    end
                RXO_MODE_DROP:
                    if (vdi_prev_r && !valid_data_ind)
                        offset_r <= '0;
                    else if (auto_ok)
                        offset_r <= lim_fn(FREQ_ERR_IN, ofs_cmd_r.offset_range_limit);
                RXO_MODE_KEEP:
                    if (auto_ok)
                        offset_r <= lim_fn(FREQ_ERR_IN, ofs_cmd_r.offset_range_limit);
                default:
                    offset_r <= offset_r;
            endcase
        end
    end

    // offset outputs
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            FREQ_OFFSET_OUT <= '0;
            SYNTH_OFFSET_OUT <= '0;
            FINE_MEASURE_OUT <= 1'b0;
            VALID_DATA_IND_OUT <= 1'b0;
        end
        else
        begin
            FREQ_OFFSET_OUT <= ofs_cmd_r.out_reg_en ? offset_r : '0;
            SYNTH_OFFSET_OUT <= (ofs_cmd_r.out_reg_en && ofs_cmd_r.synth_add_en)
                ? offset_r : '0;
            FINE_MEASURE_OUT <= ofs_cmd_r.fine_measure_en;
            VALID_DATA_IND_OUT <= valid_data_ind;
        end
    end

    // recovery speed, auto-sleep and filter select
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            RECOVERY_FAST_OUT <= 1'b0;
            STANDBY_REQ_OUT <= 1'b0;
            FILTER_ANALOG_OUT <= 1'b0;
        end
        else
        begin
            if (flt_cmd_r.recovery_auto_lock)
                RECOVERY_FAST_OUT <= ~RECOVERY_LOCK_IN;
            else
                RECOVERY_FAST_OUT <= flt_cmd_r.recovery_fast_sel;
            STANDBY_REQ_OUT <= FIFO_IRQ_IN & ~flt_cmd_r.auto_sleep_dis;
            FILTER_ANALOG_OUT <= flt_cmd_r.filter_type_sel;
        end
    end

    // digital filter: integrator stepped at a bit-rate derived tick
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
        begin
            tick_cnt_r <= 7'h00;
            acc_r <= 4'h0;
            dig_out_r <= 1'b0;
        end
        else if (tick_cnt_r >= BIT_RATE_DIV_IN)
        begin
            tick_cnt_r <= 7'h00;
            if (DEMOD_IN && acc_r != 4'hF)
                acc_r <= acc_r + 4'h1;
            else if (!DEMOD_IN && acc_r != 4'h0)
                acc_r <= acc_r - 4'h1;
            if (acc_r >= `RXO_FLT_HI)
                dig_out_r <= 1'b1;
            else if (acc_r <= `RXO_FLT_LO)
                dig_out_r <= 1'b0;
        end
        else
            tick_cnt_r <= tick_cnt_r + 7'h01;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_B_IN)
            FILT_DATA_OUT <= 1'b0;
        else
            FILT_DATA_OUT <= flt_cmd_r.filter_type_sel ? ANALOG_FILT_IN : dig_out_r;
    end
endmodule : rxo_ctrl_top

`default_nettype wire

// >>> bench/rxo_ctrl_checker.sv
// Purpose: concurrent checks on the receiver control ports
// Assumes: one clock domain, synchronous active low reset
// Notes: bound to rxo_ctrl_top from the testbench top file
`timescale 1ns/10ps
`default_nettype none

module rxo_ctrl_checker #(
    parameter int OW = 8,
    parameter int MEAS_CYC = 8
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    // serial control pins
    input wire logic SCK_IN,
    input wire logic SDI_IN,
    input wire logic SEL_B_IN,
    input wire logic SDO_OUT,
    // receiver state
    input wire logic XTAL_ON_IN,
    input wire logic SLEEP_IN,
    input wire logic [1:0] VALID_IND_SRC_SEL_IN,
    input wire logic SIGNAL_LEVEL_FLAG_IN,
    input wire logic DATA_QUALITY_FLAG_IN,
    input wire logic RECOVERY_LOCK_IN,
    input wire logic FIFO_IRQ_IN,
    input wire logic ANALOG_FILT_IN,
    // watched outputs
    input wire logic CLK_OUT_OUT,
    input wire logic [11:0] SUPPLY_THRESH_MV_OUT,
    input wire logic VALID_DATA_IND_OUT,
    input wire logic signed [OW-1:0] FREQ_OFFSET_OUT,
    input wire logic signed [OW-1:0] SYNTH_OFFSET_OUT,
    input wire logic FINE_MEASURE_OUT,
    input wire logic MEASURE_TOGGLE_OUT,
    input wire logic STANDBY_REQ_OUT,
    input wire logic FILTER_ANALOG_OUT,
    input wire logic FILT_DATA_OUT
);
    logic [3:0] vsrc;
    assign vsrc = {1'b1, RECOVERY_LOCK_IN, DATA_QUALITY_FLAG_IN, SIGNAL_LEVEL_FLAG_IN};

    logic sck_q;
    logic any_bit_r;
    logic rd_r;

    // read command: first shifted bit of a frame is zero
    always_ff @(posedge CLK_SYS_IN)
    begin
        sck_q <= SCK_IN;
        if (SEL_B_IN)
        begin
            any_bit_r <= 1'b0;
            rd_r <= 1'b0;
        end
        else if (SCK_IN && !sck_q && !any_bit_r)
        begin
            any_bit_r <= 1'b1;
            rd_r <= !SDI_IN;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_B_IN);

    a_reset_values: assert property (
        $rose(RST_B_IN) |=> SUPPLY_THRESH_MV_OUT == 12'h8FC && FREQ_OFFSET_OUT == '0
            && FINE_MEASURE_OUT)
        else $error("values after reset wrong");
    a_thresh_steps: assert property (
        SUPPLY_THRESH_MV_OUT >= 12'h7D0 && SUPPLY_THRESH_MV_OUT <= 12'hDAC
            && (SUPPLY_THRESH_MV_OUT - 12'h7D0) % 12'h064 == 12'h000)
        else $error("supply threshold off grid");
    a_standby_needs_irq: assert property (
        !FIFO_IRQ_IN |=> !STANDBY_REQ_OUT)
        else $error("standby without fifo interrupt");
    a_synth_follows: assert property (
        SYNTH_OFFSET_OUT != '0 |-> SYNTH_OFFSET_OUT == FREQ_OFFSET_OUT)
        else $error("synthesizer offset differs");
    a_analog_path: assert property (
        FILTER_ANALOG_OUT && $past(FILTER_ANALOG_OUT) |-> FILT_DATA_OUT == $past(ANALOG_FILT_IN))
        else $error("analog filter path not passed");
    a_valid_select: assert property (
        $past(RST_B_IN) |-> VALID_DATA_IND_OUT == $past(vsrc[VALID_IND_SRC_SEL_IN]))
        else $error("valid data source wrong");
    a_toggle_spacing: assert property (
        $changed(MEASURE_TOGGLE_OUT) |=> $stable(MEASURE_TOGGLE_OUT)[*6]
            ##[1:40] $changed(MEASURE_TOGGLE_OUT))
        else $error("measure toggle spacing wrong");
    a_clk_stopped: assert property (
        (!XTAL_ON_IN && !SLEEP_IN)[*3] |-> !CLK_OUT_OUT)
        else $error("clock output runs without oscillator");
    a_status_flag: assert property (
        SDO_OUT == $past(rd_r && !SEL_B_IN && MEASURE_TOGGLE_OUT))
        else $error("status flag not on serial output");

    c_offset_moved: cover property ($changed(FREQ_OFFSET_OUT));
    c_standby: cover property ($rose(STANDBY_REQ_OUT));
    c_sleep_clock: cover property (SLEEP_IN && $rose(CLK_OUT_OUT));
    c_status_read: cover property ($rose(SDO_OUT));
endmodule : rxo_ctrl_checker
`default_nettype wire

// >>> bench/rxo_host_model.sv
// Purpose: host side of the serial control interface
// Assumes: driven from the system clock falling edge
// Notes: send shifts n bits msb first; n below 16 makes a short word
`timescale 1ns/10ps
`default_nettype none

module rxo_host_model (
    // clock
    input wire logic clk_in,
    // serial pins
    output logic sck_out,
    output logic sdi_out,
    output logic sel_b_out
);
    initial
    begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        sel_b_out = 1'b1;
    end

    // top n bits of the word, two clocks per level
    task automatic send(input logic [15:0] w, input int n);
        int i;
        @(negedge clk_in);
        sel_b_out = 1'b0;
        for (i = 15; i > 15 - n; i--)
        begin
            sdi_out = w[i];
            repeat (2) @(negedge clk_in);
            sck_out = 1'b1;
            repeat (2) @(negedge clk_in);
            sck_out = 1'b0;
        end
        repeat (2) @(negedge clk_in);
        sel_b_out = 1'b1;
        // released line must not look held
        sdi_out = ~sdi_out;
        repeat (4) @(negedge clk_in);
    endtask : send
endmodule : rxo_host_model
`default_nettype wire

// >>> bench/rx_offset_clkdiv_filter_ctrl_test.sv
// Purpose: self-checking bench of the receiver control words
// Assumes: measurement cycle shortened to 8 clocks
// Notes: expected values queued by the driver, compared by a monitor
`timescale 1ns/10ps
`default_nettype none

module rx_offset_clkdiv_filter_ctrl_test;
    localparam int MC = 8;
    typedef struct {int unsigned sel; logic [15:0] v;} rxo_note_t;
    logic CLK_SYS_IN, RST_B_IN, SCK_IN, SDI_IN, SEL_B_IN, XTAL_ON_IN, SLEEP_IN;
    logic CLK_OUT_DISABLE_IN, SIGNAL_LEVEL_FLAG_IN, DATA_QUALITY_FLAG_IN, RECOVERY_LOCK_IN;
    logic FIFO_IRQ_IN, DEMOD_IN, ANALOG_FILT_IN;
    logic [1:0] VALID_IND_SRC_SEL_IN;
    logic [6:0] BIT_RATE_DIV_IN;
    logic signed [7:0] FREQ_ERR_IN, FREQ_OFFSET_OUT, SYNTH_OFFSET_OUT;
    logic [11:0] SUPPLY_THRESH_MV_OUT;
    logic SDO_OUT, CLK_OUT_OUT, VALID_DATA_IND_OUT, FINE_MEASURE_OUT, MEASURE_TOGGLE_OUT;
    logic RECOVERY_FAST_OUT, STANDBY_REQ_OUT, FILTER_ANALOG_OUT, FILT_DATA_OUT;
    logic [15:0] edge_cnt;
    int failures = 0;
    int cmp_count = 0;
    int chg_tab[9] = '{12, 15, 20, 24, 30, 40, 60, 120, 4};
    string nm[10] = '{"thresh", "offset", "synth", "fine", "fast", "standby", "analog",
        "valid", "filt", "edges"};
    rxo_note_t notes[$];
    event chk_ev;

    rxo_host_model host (.clk_in(CLK_SYS_IN), .sck_out(SCK_IN), .sdi_out(SDI_IN),
        .sel_b_out(SEL_B_IN));
    rxo_ctrl_top #(.MEAS_CYC(MC)) dut (.*);

    initial
    begin
        CLK_SYS_IN = 1'b0;
        forever #2.5 CLK_SYS_IN = ~CLK_SYS_IN;
    end

    function automatic logic [15:0] obs(input int unsigned s);
        case (s)
            0: obs = {4'h0, SUPPLY_THRESH_MV_OUT};
            1: obs = {8'h00, FREQ_OFFSET_OUT};
            2: obs = {8'h00, SYNTH_OFFSET_OUT};
            3: obs = {15'h0000, FINE_MEASURE_OUT};
            4: obs = {15'h0000, RECOVERY_FAST_OUT};
            5: obs = {15'h0000, STANDBY_REQ_OUT};
            6: obs = {15'h0000, FILTER_ANALOG_OUT};
            7: obs = {15'h0000, VALID_DATA_IND_OUT};
            8: obs = {15'h0000, FILT_DATA_OUT};
            default: obs = edge_cnt;
        endcase
    endfunction : obs

    always @(chk_ev)
    begin
        while (notes.size() > 0)
        begin
            rxo_note_t n;
            n = notes.pop_front();
            cmp_count++;
            if (obs(n.sel) !== n.v)
            begin
                failures++;
                $display("mismatch %s expected %h seen %h", nm[n.sel], n.v, obs(n.sel));
            end
        end
    end

    task automatic expect_val(input int unsigned s, input logic [15:0] v);
        notes.push_back('{s, v});
        -> chk_ev;
    endtask : expect_val

    function automatic logic signed [7:0] clamp(input logic signed [7:0] e, input logic [1:0] l);
        logic signed [7:0] m;
        m = (l == 2'b00) ? 8'sh7F : (8'sh08 >>> l);
        clamp = (e > m) ? m : ((e < -m) ? -m : e);
    endfunction : clamp

    task automatic strobe(input logic [7:0] lo, input logic signed [7:0] e,
        input logic signed [7:0] x);
        FREQ_ERR_IN = e;
        host.send({8'hC6, lo}, 16);
        host.send({8'hC6, lo | 8'h08}, 16);
        expect_val(1, lo[1] ? {8'h00, x} : 16'h0000);
        expect_val(2, &lo[1:0] ? {8'h00, x} : 16'h0000);
    endtask : strobe

    task automatic auto_run(input logic [7:0] lo, input logic signed [7:0] e,
        input logic [1:0] src, input logic signed [7:0] x);
        FREQ_ERR_IN = e;
        VALID_IND_SRC_SEL_IN = src;
        host.send({8'hC6, lo}, 16);
        repeat (6 * MC) @(negedge CLK_SYS_IN);
        expect_val(1, {8'h00, x});
    endtask : auto_run

    task automatic count_edges(input int w);
        logic prev;
        edge_cnt = 16'h0000;
        prev = CLK_OUT_OUT;
        repeat (w)
        begin
            @(negedge CLK_SYS_IN);
            if (CLK_OUT_OUT !== prev)
                edge_cnt++;
            prev = CLK_OUT_OUT;
        end
    endtask : count_edges

    task automatic stop_test;
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial
    begin
        int i;
        logic signed [7:0] e;
        logic [3:0] v;
        {XTAL_ON_IN, SLEEP_IN, CLK_OUT_DISABLE_IN, FIFO_IRQ_IN, DEMOD_IN} = 5'h00;
        {SIGNAL_LEVEL_FLAG_IN, DATA_QUALITY_FLAG_IN, RECOVERY_LOCK_IN} = 3'h0;
        ANALOG_FILT_IN = 1'b0;
        VALID_IND_SRC_SEL_IN = 2'h0;
        BIT_RATE_DIV_IN = 7'h03;
        FREQ_ERR_IN = 8'h00;
        RST_B_IN = 1'b0;
        void'($urandom(32'hB566));
        repeat (8) @(negedge CLK_SYS_IN);
        RST_B_IN = 1'b1;
        repeat (2) @(negedge CLK_SYS_IN);
        expect_val(0, 16'h08FC);
        expect_val(1, 16'h0000);
        expect_val(3, 16'h0001);
        expect_val(4, 16'h0001);
        expect_val(6, 16'h0000);
        for (i = 0; i < 16; i++)
        begin
            host.send({8'hC2, 3'($urandom), 1'b0, i[3:0]}, 16);
            expect_val(0, 16'h07D0 + 16'h0064 * 16'(i));
        end
        host.send(16'hC200, 15);
        host.send(16'hC300, 16);
        expect_val(0, 16'h0DAC);
        XTAL_ON_IN = 1'b1;
        for (i = 0; i < 9; i++)
        begin
            SLEEP_IN = (i == 8);
            CLK_OUT_DISABLE_IN = (i == 8);
            host.send({8'hC2, i[2:0], i[3], 4'h3}, 16);
            repeat (i == 8 ? 3200 : 300) @(negedge CLK_SYS_IN);
            count_edges(i == 8 ? 12500 : 1200);
            expect_val(9, 16'(chg_tab[i]));
        end
        SLEEP_IN = 1'b0;
        XTAL_ON_IN = 1'b0;
        host.send(16'hC603, 16);
        expect_val(3, 16'h0000);
        for (i = 0; i < 4; i++)
        begin
            e = 8'($urandom_range(100, 5));
            e = i[0] ? -e : e;
            strobe({2'b00, i[1:0], 4'h3}, e, clamp(e, i[1:0]));
        end
        strobe(8'h01, 8'sh09, 8'sh09);
        e = 8'($urandom_range(60, 1));
        auto_run(8'hC3, e, 2'b11, e);
        auto_run(8'hC3, -e, 2'b00, e);
        auto_run(8'h83, e + 8'sh05, 2'b11, e + 8'sh05);
        auto_run(8'h83, e, 2'b00, 8'sh00);
        auto_run(8'h43, -e, 2'b11, -e);
        auto_run(8'h43, e, 2'b11, -e);
        for (i = 0; i < 8; i++)
        begin
            v = {1'b1, 3'($urandom)};
            {RECOVERY_LOCK_IN, DATA_QUALITY_FLAG_IN, SIGNAL_LEVEL_FLAG_IN} = v[2:0];
            VALID_IND_SRC_SEL_IN = i[1:0];
            repeat (2) @(negedge CLK_SYS_IN);
            expect_val(7, {15'h0000, v[i[1:0]]});
        end
        FIFO_IRQ_IN = 1'b1;
        for (i = 0; i < 16; i++)
        begin
            RECOVERY_LOCK_IN = 1'($urandom);
            ANALOG_FILT_IN = 1'($urandom);
            host.send({8'hC4, i[3:0], 4'h2}, 16);
            expect_val(4, {15'h0000, i[3] ? ~RECOVERY_LOCK_IN : i[2]});
            expect_val(5, {15'h0000, ~i[1]});
            expect_val(6, {15'h0000, i[0]});
        end
        FIFO_IRQ_IN = 1'b0;
        host.send(16'h0000, 16);
        host.send(16'hC482, 16);
        for (i = 0; i < 8; i++)
        begin
            DEMOD_IN = ~DEMOD_IN;
            repeat (4) @(negedge CLK_SYS_IN);
        end
        for (i = 0; i < 2; i++)
        begin
            DEMOD_IN = ~i[0];
            repeat (100) @(negedge CLK_SYS_IN);
            expect_val(8, {15'h0000, ~i[0]});
        end
        @(negedge CLK_SYS_IN);
        stop_test();
    end

    initial
    begin
        repeat (80000) @(posedge CLK_SYS_IN);
        failures++;
        stop_test();
    end
endmodule : rx_offset_clkdiv_filter_ctrl_test

bind rxo_ctrl_top rxo_ctrl_checker #(.OW(OW), .MEAS_CYC(MEAS_CYC)) u_chk (.*);
`default_nettype wire
